// ### ilas_config_record.sv
// link configuration record octets and checksum for one lane
`timescale 1ns/10ps
module ilas_config_record (
  input wire logic [31:0] ids_in,
  input wire logic [31:0] geom_in,
  input wire logic [31:0] samp_in,
  input wire logic scramble_in,
  input wire logic [3:0] idx_in,
  output logic [7:0] octet_out,
  output logic [7:0] checksum_out
);
  logic [7:0] oct [0:12];
  logic adj_ok;
  logic [7:0] sum;
  // adjust fields sent only in subclass 2
  assign adj_ok = samp_in[ilas_pkg::SUBCL_LSB +: 3] == ilas_pkg::SUBCLASS_2;
  always_comb begin
    oct[0] = ids_in[ilas_pkg::DEV_ID_LSB +: 8];
    oct[1] = {ids_in[ilas_pkg::ADJ_STEPS_LSB +: 4] & {4{adj_ok}},
              ids_in[ilas_pkg::BANK_ID_LSB +: 4]};
    oct[2] = {1'b0, ids_in[ilas_pkg::ADJ_DIR_BIT] & adj_ok,
              ids_in[ilas_pkg::PHASE_REQ_BIT] & adj_ok,
              ids_in[ilas_pkg::LANEID_LSB +: 5]};
    oct[3] = {scramble_in, 2'b00, geom_in[ilas_pkg::LANES_LSB +: 5]};
    oct[4] = geom_in[ilas_pkg::FOCT_LSB +: 8];
    oct[5] = {3'b000, geom_in[ilas_pkg::KFRM_LSB +: 5]};
    oct[6] = geom_in[ilas_pkg::MCONV_LSB +: 8];
    oct[7] = {samp_in[ilas_pkg::CS_LSB +: 2], 1'b0,
              samp_in[ilas_pkg::NRES_LSB +: 5]};
    oct[8] = {samp_in[ilas_pkg::SUBCL_LSB +: 3],
              samp_in[ilas_pkg::NTOT_LSB +: 5]};
    oct[9] = {samp_in[ilas_pkg::VER_LSB +: 3],
              samp_in[ilas_pkg::SPF_LSB +: 5]};
    oct[10] = {samp_in[ilas_pkg::DENSITY_BIT], 2'b00,
               samp_in[ilas_pkg::CTRL_WORDS_LSB +: 5]};
    oct[11] = 8'h00;
    oct[12] = 8'h00;
  end
  // modulo 256 sum of the first thirteen octets
  always_comb begin
    sum = 8'h00;
    for (int i = 0; i < 13; i++) begin
      sum = 8'(sum + oct[i]);
    end
  end
  assign checksum_out = sum;
  assign octet_out = (idx_in == ilas_pkg::CFG_CHK_IDX) ? sum :
                     (idx_in > ilas_pkg::CFG_CHK_IDX) ? 8'h00 : oct[idx_in];
endmodule

// ### ilas_pkg.sv
// constants, register map and state type of the alignment sequence block
package ilas_pkg;
  // control characters as octets for the lane encoder
  localparam logic [7:0] K_SYNC = 8'hbc;
  localparam logic [7:0] K_START = 8'h1c;
  localparam logic [7:0] K_ALIGN = 8'h7c;
  localparam logic [7:0] K_CONFIG = 8'h9c;
  localparam logic [7:0] K_FRAME = 8'hfc;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LEN = 8'h04;
  localparam logic [7:0] OFS_IDS = 8'h08;
  localparam logic [7:0] OFS_GEOM = 8'h0c;
  localparam logic [7:0] OFS_SAMP = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // control register bits
  localparam int CTRL_LANE_SYNC = 0;
  localparam int CTRL_LOOP = 1;
  localparam int CTRL_REINIT = 2;
  localparam int CTRL_SCRAMBLE = 3;
  // reset values
  localparam logic LANE_SYNC_RST = 1'b1;
  localparam logic LOOP_RST = 1'b0;
  localparam logic SCRAMBLE_RST = 1'b0;
  localparam logic [7:0] LEN_RST = 8'h03;
  localparam logic [7:0] DEFAULT_MF_M1 = 8'h03;
  localparam logic [31:0] IDS_RST = 32'h00000000;
  localparam logic [31:0] GEOM_RST = 32'h00000000;
  localparam logic [31:0] SAMP_RST = 32'h00000000;
  // identifier register fields
  localparam int DEV_ID_LSB = 0;
  localparam int BANK_ID_LSB = 8;
  localparam int ADJ_STEPS_LSB = 12;
  localparam int LANEID_LSB = 16;
  localparam int PHASE_REQ_BIT = 21;
  localparam int ADJ_DIR_BIT = 22;
  // geometry register fields
  localparam int LANES_LSB = 0;
  localparam int FOCT_LSB = 8;
  localparam int KFRM_LSB = 16;
  localparam int MCONV_LSB = 24;
  // sample register fields
  localparam int NRES_LSB = 0;
  localparam int CS_LSB = 6;
  localparam int NTOT_LSB = 8;
  localparam int SUBCL_LSB = 13;
  localparam int SPF_LSB = 16;
  localparam int VER_LSB = 21;
  localparam int CTRL_WORDS_LSB = 24;
  localparam int DENSITY_BIT = 29;
  localparam logic [2:0] SUBCLASS_0 = 3'h0;
  localparam logic [2:0] SUBCLASS_2 = 3'h2;
  // placement of the configuration record in the second multiframe
  localparam logic [7:0] CFG_MF = 8'h01;
  localparam logic [12:0] Q_POS = 13'h0001;
  localparam logic [12:0] CFG_FIRST_POS = 13'h0002;
  localparam logic [12:0] CFG_LAST_POS = 13'h000f;
  localparam logic [3:0] CFG_CHK_IDX = 4'hd;
  localparam logic [7:0] MF_CNT_MAX = 8'hff;
  typedef enum logic [3:0] {
    ST_SYNC = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_ILAS = 4'b0100,
    ST_DATA = 4'b1000
  } link_state_type;
endpackage

// ### ilas_rx_model.sv
// receiver model: holds its sync request until five sync characters in a row arrive
`timescale 1ns/10ps
module ilas_rx_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] octet_in,
  input wire logic control_in,
  input wire logic resync_in,
  output logic sync_request_n_out
);
  logic [2:0] k_cnt_r;
  logic is_k;
  assign is_k = control_in && (octet_in == 8'hbc);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      k_cnt_r <= 3'h0;
      sync_request_n_out <= 1'b0;
    end else if (resync_in) begin
      // request held low: transmitter must fall back to sync characters
      k_cnt_r <= 3'h0;
      sync_request_n_out <= 1'b0;
    end else if (!sync_request_n_out && is_k && k_cnt_r != 3'h4) begin
      k_cnt_r <= k_cnt_r + 3'h1;
    end else if (!sync_request_n_out && !is_k) begin
      k_cnt_r <= 3'h0;
    end else if (k_cnt_r == 3'h4) begin
      sync_request_n_out <= 1'b1;
    end
  end
endmodule

// ### ilas_sync_in.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/10ps
module ilas_sync_in #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule

// ### tx_initial_lane_alignment_seq.sv
// link layer octet generator: sync characters, alignment sequence, user data
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - lane sync enable on sends alignment after sync, else straight to data
// - alignment sequence lasts four multiframes by default
// - subclass 0 length register extends sequence up to 256 multiframes
// - alignment octets are never marked for scrambling
// - every alignment multiframe starts with /R/ and ends with /A/
// - second multiframe sends /R/, /Q/, fourteen config octets, filler, /A/
// - filler comes from eight-bit counter held at zero outside alignment
// - extra multiframes keep /R/ first, /A/ last, filler between
// - config octets 0 to 2 carry ids, adjust fields and lane id
// - config octets 3 to 5 carry scrambling flag, lanes, F, K
// - config octets 6 to 8 carry M, CS, N, subclass, total bits
// - config octets 9 and 10 carry version, S, density flag, control words
// - config octets 11 and 12 are sent as zero
// - config octet 13 is modulo 256 sum of preceding thirteen
// - adjust fields only meaningful in subclass 2, else sent zero
// - loop bit holds alignment phase until bit is cleared
// - in loop, receiver sync request then release starts held alignment
// - in loop, register reinit sends /K/ then alignment after release
// - looping multiframes keep /R/ and /A/ with incrementing filler
// - user data gets /F/ and /A/ substitution only where data allows
// - while sync request is low, continuous /K28.5/ is sent
// - subclass 1 and 2 start alignment at next multiframe clock boundary
module tx_initial_lane_alignment_seq (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic sync_request_n_in,
  input wire logic lmfc_boundary_in,
  input wire logic [7:0] user_octet_in,
  output logic user_ready_out,
  output logic [7:0] octet_out,
  output logic control_out,
  output logic scrambled_out
);
  ilas_pkg::link_state_type state_r, state_nxt;
  logic lane_sync_en_r, loop_r, scramble_r, reinit_r, reinit_hold_r;
  logic [7:0] len_r;
  logic [31:0] ids_r, geom_r, samp_r;
  logic sync_n_s;
  logic [7:0] oct_cnt_r, mf_cnt_r, dummy_r, prev_last_r;
  logic [4:0] frm_cnt_r;
  logic [12:0] mf_pos_r;
  logic prev_align_r;
  logic frame_last, mf_last, boundary, restart, subclass0;
  logic [7:0] eff_len, cfg_octet, checksum;
  logic [3:0] cfg_idx;
  logic apb_acc, apb_wr, apb_rd_ok;
  logic [7:0] octet_nxt;
  logic control_nxt;

  ilas_sync_in #(.RST_VAL(1'b0)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(sync_request_n_in),
    .q_out(sync_n_s)
  );

  ilas_config_record u_cfg (
    .ids_in(ids_r),
    .geom_in(geom_r),
    .samp_in(samp_r),
    .scramble_in(scramble_r),
    .idx_in(cfg_idx),
    .octet_out(cfg_octet),
    .checksum_out(checksum)
  );

  // apb slave, one wait state in every access
  assign apb_acc = psel_in && penable_in && pready_out;
  assign apb_wr = apb_acc && pwrite_in;
  always_comb begin
    unique case (paddr_in)
      ilas_pkg::OFS_CTRL, ilas_pkg::OFS_LEN, ilas_pkg::OFS_IDS,
      ilas_pkg::OFS_GEOM, ilas_pkg::OFS_SAMP,
      ilas_pkg::OFS_STATUS: apb_rd_ok = 1'b1;
      default: apb_rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h00000000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
      if (psel_in && penable_in && !pready_out) begin
        pslverr_out <= !apb_rd_ok || (pwrite_in &&
                       paddr_in == ilas_pkg::OFS_STATUS);
        unique case (paddr_in)
          ilas_pkg::OFS_CTRL: prdata_out <= {28'h0000000, scramble_r,
                                reinit_hold_r, loop_r, lane_sync_en_r};
          ilas_pkg::OFS_LEN: prdata_out <= {24'h000000, len_r};
          ilas_pkg::OFS_IDS: prdata_out <= ids_r;
          ilas_pkg::OFS_GEOM: prdata_out <= geom_r;
          ilas_pkg::OFS_SAMP: prdata_out <= samp_r;
          ilas_pkg::OFS_STATUS: prdata_out <= {8'h00, mf_cnt_r, checksum,
                                  3'b000, sync_n_s, state_r};
          default: prdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // software settings
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lane_sync_en_r <= ilas_pkg::LANE_SYNC_RST;
      loop_r <= ilas_pkg::LOOP_RST;
      scramble_r <= ilas_pkg::SCRAMBLE_RST;
      len_r <= ilas_pkg::LEN_RST;
      ids_r <= ilas_pkg::IDS_RST;
      geom_r <= ilas_pkg::GEOM_RST;
      samp_r <= ilas_pkg::SAMP_RST;
      reinit_r <= 1'b0;
    end else begin
      reinit_r <= apb_wr && paddr_in == ilas_pkg::OFS_CTRL &&
                  pwdata_in[ilas_pkg::CTRL_REINIT];
      if (apb_wr) begin
        unique case (paddr_in)
          ilas_pkg::OFS_CTRL: begin
            lane_sync_en_r <= pwdata_in[ilas_pkg::CTRL_LANE_SYNC];
            loop_r <= pwdata_in[ilas_pkg::CTRL_LOOP];
            scramble_r <= pwdata_in[ilas_pkg::CTRL_SCRAMBLE];
          end
          ilas_pkg::OFS_LEN: len_r <= pwdata_in[7:0];
          ilas_pkg::OFS_IDS: ids_r <= pwdata_in;
          ilas_pkg::OFS_GEOM: geom_r <= pwdata_in;
          ilas_pkg::OFS_SAMP: samp_r <= pwdata_in;
          default: ;
        endcase
      end
    end
  end

  // reinit keeps /K/ going until the receiver has asked for sync
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reinit_hold_r <= 1'b0;
    end else if (reinit_r) begin
      reinit_hold_r <= 1'b1;
    end else if (!sync_n_s) begin
      reinit_hold_r <= 1'b0;
    end
  end

  // frame and multiframe position
  assign frame_last = oct_cnt_r == geom_r[ilas_pkg::FOCT_LSB +: 8];
  assign mf_last = frame_last &&
                   frm_cnt_r == geom_r[ilas_pkg::KFRM_LSB +: 5];
  assign subclass0 = samp_r[ilas_pkg::SUBCL_LSB +: 3] == ilas_pkg::SUBCLASS_0;
  assign boundary = subclass0 ? frame_last : lmfc_boundary_in;
  assign eff_len = subclass0 ? len_r : ilas_pkg::DEFAULT_MF_M1;
  assign restart = state_r == ilas_pkg::ST_WAIT && state_nxt != state_r;
  assign cfg_idx = 4'(mf_pos_r[3:0] - ilas_pkg::CFG_FIRST_POS[3:0]);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ilas_pkg::ST_SYNC:
        if (sync_n_s && !reinit_hold_r) state_nxt = ilas_pkg::ST_WAIT;
      ilas_pkg::ST_WAIT:
        if (boundary) begin
          state_nxt = lane_sync_en_r ? ilas_pkg::ST_ILAS :
                      ilas_pkg::ST_DATA;
        end
      ilas_pkg::ST_ILAS:
        if (mf_last && mf_cnt_r >= eff_len && !loop_r) begin
          state_nxt = ilas_pkg::ST_DATA;
        end
      ilas_pkg::ST_DATA: ;
      default: state_nxt = ilas_pkg::ST_SYNC;
    endcase
    if (!sync_n_s || reinit_r) state_nxt = ilas_pkg::ST_SYNC;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ilas_pkg::ST_SYNC;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      oct_cnt_r <= 8'h00;
      frm_cnt_r <= 5'h00;
      mf_pos_r <= 13'h0000;
    end else if (restart || mf_last) begin
      oct_cnt_r <= 8'h00;
      frm_cnt_r <= 5'h00;
      mf_pos_r <= 13'h0000;
    end else if (frame_last) begin
      oct_cnt_r <= 8'h00;
      frm_cnt_r <= 5'(frm_cnt_r + 5'h01);
      mf_pos_r <= 13'(mf_pos_r + 13'h0001);
    end else begin
      oct_cnt_r <= 8'(oct_cnt_r + 8'h01);
      mf_pos_r <= 13'(mf_pos_r + 13'h0001);
    end
  end

  // multiframe count and filler counter live only in alignment
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mf_cnt_r <= 8'h00;
      dummy_r <= 8'h00;
    end else if (state_r != ilas_pkg::ST_ILAS) begin
      mf_cnt_r <= 8'h00;
      dummy_r <= 8'h00;
    end else begin
      dummy_r <= 8'(dummy_r + 8'h01);
      if (mf_last && mf_cnt_r != ilas_pkg::MF_CNT_MAX) begin
        mf_cnt_r <= 8'(mf_cnt_r + 8'h01);
      end
    end
  end

  // octet selection
  always_comb begin
    octet_nxt = ilas_pkg::K_SYNC;
    control_nxt = 1'b1;
    unique case (state_r)
      ilas_pkg::ST_SYNC, ilas_pkg::ST_WAIT: ;
      ilas_pkg::ST_ILAS:
        if (mf_pos_r == 13'h0000) begin
          octet_nxt = ilas_pkg::K_START;
        end else if (mf_last) begin
          octet_nxt = ilas_pkg::K_ALIGN;
        end else if (mf_cnt_r == ilas_pkg::CFG_MF &&
                     mf_pos_r == ilas_pkg::Q_POS) begin
          octet_nxt = ilas_pkg::K_CONFIG;
        end else if (mf_cnt_r == ilas_pkg::CFG_MF &&
                     mf_pos_r >= ilas_pkg::CFG_FIRST_POS &&
                     mf_pos_r <= ilas_pkg::CFG_LAST_POS) begin
          octet_nxt = cfg_octet;
          control_nxt = 1'b0;
        end else begin
          octet_nxt = dummy_r;
          control_nxt = 1'b0;
        end
      ilas_pkg::ST_DATA: begin
        octet_nxt = user_octet_in;
        control_nxt = 1'b0;
        if (scramble_r) begin
          if (mf_last) begin
            control_nxt = user_octet_in == ilas_pkg::K_ALIGN;
          end else if (frame_last) begin
            control_nxt = user_octet_in == ilas_pkg::K_FRAME;
          end
        end else if (frame_last && user_octet_in == prev_last_r) begin
          if (mf_last) begin
            octet_nxt = ilas_pkg::K_ALIGN;
            control_nxt = 1'b1;
          end else if (!prev_align_r) begin
            octet_nxt = ilas_pkg::K_FRAME;
            control_nxt = 1'b1;
          end
        end
      end
      default: ;
    endcase
  end

  // last octet of the previous frame, for unscrambled substitution
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_last_r <= 8'h00;
      prev_align_r <= 1'b1;
    end else if (state_r != ilas_pkg::ST_DATA) begin
      prev_last_r <= 8'h00;
      prev_align_r <= 1'b1;
    end else if (frame_last) begin
      prev_last_r <= user_octet_in;
      prev_align_r <= control_nxt;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      octet_out <= ilas_pkg::K_SYNC;
      control_out <= 1'b1;
      scrambled_out <= 1'b0;
      user_ready_out <= 1'b0;
    end else begin
      octet_out <= octet_nxt;
      control_out <= control_nxt;
      scrambled_out <= state_r == ilas_pkg::ST_DATA && scramble_r;
      user_ready_out <= state_nxt == ilas_pkg::ST_DATA;
    end
  end

  sequence s_octet(logic [7:0] v, logic k);
    octet_out == v && control_out == k;
  endsequence
  sequence s_in_ilas;
    state_r == ilas_pkg::ST_ILAS;
  endsequence
  a_sync_chars: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == ilas_pkg::ST_SYNC |=> s_octet(ilas_pkg::K_SYNC, 1'b1))
    else $error("sync character missing");
  a_mf_start: assert property (@(posedge clk_in) disable iff (rst_in)
    s_in_ilas and mf_pos_r == 13'h0000 |=> s_octet(ilas_pkg::K_START, 1'b1))
    else $error("multiframe not opened by start character");
  a_mf_end: assert property (@(posedge clk_in) disable iff (rst_in)
    s_in_ilas and mf_last && mf_pos_r != 13'h0000
    |=> s_octet(ilas_pkg::K_ALIGN, 1'b1))
    else $error("multiframe not closed by align character");
  a_q_after_r: assert property (@(posedge clk_in) disable iff (rst_in)
    s_in_ilas and mf_cnt_r == ilas_pkg::CFG_MF && mf_pos_r == 13'h0000 &&
    !mf_last ##1 !mf_last
    |=> s_octet(ilas_pkg::K_CONFIG, 1'b1))
    else $error("config marker not after start character");
  a_chk_octet: assert property (@(posedge clk_in) disable iff (rst_in)
    s_in_ilas and mf_cnt_r == ilas_pkg::CFG_MF &&
    mf_pos_r == ilas_pkg::CFG_LAST_POS && !mf_last
    |=> octet_out == $past(checksum) && !control_out)
    else $error("checksum octet wrong");
  a_dummy_held: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r != ilas_pkg::ST_ILAS |=> dummy_r == 8'h00 [*1])
    else $error("filler counter not held");
  a_no_scramble: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r != ilas_pkg::ST_DATA |=> !scrambled_out)
    else $error("alignment octet marked scrambled");
  a_ilas_length: assert property (@(posedge clk_in) disable iff (rst_in)
    s_in_ilas ##1 state_r == ilas_pkg::ST_DATA
    |-> $past(mf_cnt_r) >= $past(eff_len) && !$past(loop_r))
    else $error("alignment phase left too early");
  a_loop_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    s_in_ilas and loop_r && sync_n_s && !reinit_r
    |=> state_r == ilas_pkg::ST_ILAS)
    else $error("loop did not hold alignment");
  a_direct_data: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == ilas_pkg::ST_WAIT && boundary && sync_n_s && !reinit_r &&
    !lane_sync_en_r |=> state_r == ilas_pkg::ST_DATA)
    else $error("no direct entry to user data");
  a_reinit_k: assert property (@(posedge clk_in) disable iff (rst_in)
    reinit_r |=> state_r == ilas_pkg::ST_SYNC ##1
    s_octet(ilas_pkg::K_SYNC, 1'b1))
    else $error("reinit did not send sync characters");
endmodule

// ### tx_initial_lane_alignment_seq_tb.sv
// self-checking bench for the alignment sequence generator
`timescale 1ns/10ps
module tx_initial_lane_alignment_seq_tb;
  localparam int MF = 32;
  typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_type;
  logic clk_in, rst_in, psel, penable, pwrite, resync, lmfc;
  logic pready, pslverr, sync_n, user_ready, control, scrambled, err;
  logic [7:0] paddr, user_octet, octet;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] rec [14];
  row_type rows [6];
  int fails = 0;
  int n_tests = 0;
  tx_initial_lane_alignment_seq dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr),
    .sync_request_n_in(sync_n), .lmfc_boundary_in(lmfc),
    .user_octet_in(user_octet), .user_ready_out(user_ready),
    .octet_out(octet), .control_out(control), .scrambled_out(scrambled));
  ilas_rx_model rx_u (.clk_in(clk_in), .rst_in(rst_in), .octet_in(octet),
    .control_in(control), .resync_in(resync),
    .sync_request_n_out(sync_n));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse_resync;
    @(posedge clk_in);
    resync <= 1'b1;
    repeat (4) @(posedge clk_in);
    resync <= 1'b0;
  endtask
  task automatic wait_start;
    int n;
    n = 0;
    @(negedge clk_in);
    while (!(octet === ilas_pkg::K_START && control === 1'b1) && n < 2000)
    begin
      @(negedge clk_in);
      n++;
    end
    chk("start octet", {24'h0, ilas_pkg::K_START}, {24'h0, octet});
  endtask
  task automatic check_ilas(input int nmf);
    int p;
    int m;
    logic [8:0] e;
    for (int i = 0; i < nmf * MF; i++) begin
      p = i % MF;
      m = i / MF;
      e = {1'b0, i[7:0]};
      if (p == 0) begin
        e = {1'b1, ilas_pkg::K_START};
      end else if (p == MF - 1) begin
        e = {1'b1, ilas_pkg::K_ALIGN};
      end else if (m == 1 && p == 1) begin
        e = {1'b1, ilas_pkg::K_CONFIG};
      end else if (m == 1 && p < 16) begin
        e = {1'b0, rec[p-2]};
      end
      chk("ilas octet", {23'h0, e}, {23'h0, control, octet});
      chk("ilas scrambled", 32'h0, {31'h0, scrambled});
      @(negedge clk_in);
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    #100000;
    fails++;
    finish_test();
  end
  initial begin
    rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    resync = 1'b1;
    lmfc = 1'b0;
    user_octet = 8'h3a;
    rows[0] = '{ilas_pkg::OFS_CTRL, 32'h00000001, 1'b0};
    rows[1] = '{ilas_pkg::OFS_LEN, 32'h00000003, 1'b0};
    rows[2] = '{ilas_pkg::OFS_IDS, 32'h00000000, 1'b0};
    rows[3] = '{ilas_pkg::OFS_GEOM, 32'h00000000, 1'b0};
    rows[4] = '{ilas_pkg::OFS_SAMP, 32'h00000000, 1'b0};
    rows[5] = '{8'h18, 32'h00000000, 1'b1};
    rec = '{8'h5a, 8'h03, 8'h09, 8'h81, 8'h03, 8'h07, 8'h02, 8'h4f, 8'h0f,
            8'h20, 8'h80, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 13; k++) begin
      rec[13] = rec[13] + rec[k];
    end
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk("reset octet", 32'h1bc, {23'h0, control, octet});
    chk("reset ready", 32'h0, {31'h0, user_ready});
    @(posedge clk_in);
    rst_in <= 1'b0;
    for (int r = 0; r < 6; r++) begin
      apb(1'b0, rows[r].a, 32'h0);
      chk("read data", rows[r].d, q);
      chk("slverr", {31'h0, rows[r].e}, {31'h0, err});
    end
    apb(1'b1, ilas_pkg::OFS_IDS, 32'h0069535a);
    apb(1'b1, ilas_pkg::OFS_GEOM, 32'h02070301);
    apb(1'b1, ilas_pkg::OFS_SAMP, 32'h20200f4f);
    apb(1'b1, ilas_pkg::OFS_LEN, 32'h00000004);
    apb(1'b1, ilas_pkg::OFS_CTRL, 32'h00000009);
    apb(1'b0, ilas_pkg::OFS_STATUS, 32'h0);
    chk("checksum reg", {16'h0000, rec[13], 8'h01}, q);
    @(posedge clk_in);
    resync <= 1'b0;
    wait_start();
    check_ilas(5);
    chk("data octet", 32'h03a, {23'h0, control, octet});
    chk("data ready", 32'h1, {31'h0, user_ready});
    chk("data scrambled", 32'h1, {31'h0, scrambled});
    apb(1'b1, ilas_pkg::OFS_CTRL, 32'h0000000b);
    pulse_resync();
    wait_start();
    check_ilas(8);
    apb(1'b1, ilas_pkg::OFS_CTRL, 32'h00000009);
    for (int n = 0; n < 300 && user_ready !== 1'b1; n++) begin
      @(negedge clk_in);
    end
    chk("loop exit", 32'h1, {31'h0, user_ready});
    apb(1'b1, ilas_pkg::OFS_CTRL, 32'h0000000f);
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    chk("reinit octet", 32'h1bc, {23'h0, control, octet});
    pulse_resync();
    wait_start();
    check_ilas(2);
    apb(1'b1, ilas_pkg::OFS_CTRL, 32'h00000000);
    pulse_resync();
    @(negedge clk_in);
    for (int n = 0; n < 300 && !(octet === 8'hbc && control === 1'b1); n++)
    begin
      @(negedge clk_in);
    end
    chk("sync octet", 32'h1bc, {23'h0, control, octet});
    for (int n = 0; n < 300 && octet === 8'hbc && control === 1'b1; n++)
    begin
      @(negedge clk_in);
    end
    chk("skip octet", 32'h03a, {23'h0, control, octet});
    repeat (7) @(negedge clk_in);
    chk("frame sub", 32'h1fc, {23'h0, control, octet});
    repeat (24) @(negedge clk_in);
    chk("multiframe sub", 32'h17c, {23'h0, control, octet});
    finish_test();
  end
endmodule
